// File: core/accel_mag_pkg.sv
// Package for the accelerometer offset and magnetic status bank.
// Assumes one sensor clock and byte-wide register access.
package accel_mag_pkg;
    // Register addresses, index 0 is X, 1 is Y, 2 is Z
    localparam logic [2:0][7:0] ADDR_ZERO_OFFSET = {8'h31, 8'h30, 8'h2f};
    localparam logic [7:0] ADDR_MAG_STATUS = 8'h32;
    localparam logic [2:0][7:0] ADDR_MAG_MSB = {8'h37, 8'h35, 8'h33};
    localparam logic [2:0][7:0] ADDR_MAG_LSB = {8'h38, 8'h36, 8'h34};
    localparam logic [7:0] ADDR_ACCEL_FIRST = 8'h01;
    localparam logic [7:0] ADDR_ACCEL_LAST = 8'h06;
    // Status field positions
    localparam int BIT_XYZ_OW = 7;
    localparam int BIT_FIRST_OW = 4;
    localparam int BIT_XYZ_DR = 3;
    localparam int BIT_FIRST_DR = 0;
    // Reset values
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Widths and scaling
    localparam int ACCEL_W = 14;
    localparam int MAG_W = 16;
    localparam int OFFSET_W = 8;
    localparam int OFFSET_MG_PER_CODE = 2;
    localparam int OFFSET_MIN_MG = -256;
    localparam int OFFSET_MAX_MG = 254;
    // Register request from the serial interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // Three-axis acceleration sample
    typedef struct packed {
        logic [2:0][ACCEL_W-1:0] axis;
    } accel_sample_t;
    // Three-axis magnetic sample
    typedef struct packed {
        logic [2:0][MAG_W-1:0] axis;
    } mag_sample_t;
endpackage : accel_mag_pkg

// File: core/accel_offset_and_mag_status.sv
// Offset correction registers and magnetic data-ready status.
// Assumes register requests are synchronous one-cycle strobes and
// that the mode controller supplies the active flag.
`timescale 1ns/100ps
`default_nettype none
module accel_offset_and_mag_status (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire accel_mag_pkg::reg_req_t regReq,
    input wire logic deviceActive,
    input wire logic accelValid,
    input wire accel_mag_pkg::accel_sample_t accelRaw,
    input wire logic [2:0] magDone,
    input wire accel_mag_pkg::mag_sample_t magRaw,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output var accel_mag_pkg::accel_sample_t accelOut,
    output var accel_mag_pkg::mag_sample_t magOut,
    output logic [7:0] magStatus
);
    // Reset synchroniser stages
    logic rstSync1;
    logic rstSyncN;

    // Per-axis storage and flags
    logic [2:0][7:0] offsetReg;
    logic [2:0] readyReg;
    logic [2:0] readyNext;
    logic [2:0] owReg;
    logic [2:0] owSet;
    logic [2:0] msbRead;
    // Combined flags and MSB read tracking
    logic xyzReadyReg;
    logic xyzOwReg;
    logic [2:0] readSeenReg;
    logic allRead;
    logic setDone;
    // Read mux result
    logic [7:0] rdMux;

    // Release reset through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1 <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSyncN <= rstSync1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            // Read of this axis magnetic MSB
            assign msbRead[i] = regReq.rd &&
                (regReq.addr == accel_mag_pkg::ADDR_MAG_MSB[i]);
            assign readyNext[i] = magDone[i] |
                (readyReg[i] & ~msbRead[i]);
            assign owSet[i] = magDone[i] & readyReg[i] & ~msbRead[i];

            // Offset register, held in active mode
            always_ff @(posedge core_clk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    offsetReg[i] <= accel_mag_pkg::OFFSET_RESET;
                end else if (regReq.wr && !deviceActive &&
                    regReq.addr == accel_mag_pkg::ADDR_ZERO_OFFSET[i]) begin
                    offsetReg[i] <= regReq.wdata;
                end
            end

            // Corrected acceleration output
            always_ff @(posedge core_clk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    accelOut.axis[i] <= '0;
                end else if (accelValid) begin
                    accelOut.axis[i] <= accelRaw.axis[i] +
                        {{(accel_mag_pkg::ACCEL_W - 8){offsetReg[i][7]}},
                        offsetReg[i]};
                end
            end

            // Magnetic output latch
            always_ff @(posedge core_clk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    magOut.axis[i] <= '0;
                end else if (magDone[i]) begin
                    magOut.axis[i] <= magRaw.axis[i];
                end
            end

            // Axis ready and overwrite flags
            always_ff @(posedge core_clk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    readyReg[i] <= 1'b0;
                    owReg[i] <= 1'b0;
                end else begin
                    readyReg[i] <= readyNext[i];
                    owReg[i] <= owSet[i] | (owReg[i] & ~msbRead[i]);
                end
            end
        end
    endgenerate

    // All three MSBs read since last set
    assign allRead = &(readSeenReg | msbRead);
    // Completed full set event
    assign setDone = (|magDone) & (&readyNext);

    // Combined flags and read tracking
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            xyzReadyReg <= 1'b0;
            xyzOwReg <= 1'b0;
            readSeenReg <= 3'h0;
        end else begin
            xyzReadyReg <= setDone | (xyzReadyReg & ~allRead);
            xyzOwReg <= (|owSet) | (xyzOwReg & ~allRead);
            // Track reads, restart on set or full read
            if (setDone || allRead) begin
                readSeenReg <= 3'h0;
            end else begin
                readSeenReg <= readSeenReg | msbRead;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            magStatus <= accel_mag_pkg::STATUS_RESET;
        end else begin
            magStatus <= {xyzOwReg, owReg, xyzReadyReg, readyReg};
        end
    end

    // Read data selection
    always_comb begin
        rdMux = 8'h00;
        if (regReq.addr == accel_mag_pkg::ADDR_MAG_STATUS) begin
            rdMux = magStatus;
        end
        for (int k = 0; k < 3; k++) begin
            if (regReq.addr == accel_mag_pkg::ADDR_ZERO_OFFSET[k]) begin
                rdMux = offsetReg[k];
            end
            if (regReq.addr == accel_mag_pkg::ADDR_MAG_MSB[k]) begin
                rdMux = magOut.axis[k][15:8];
            end
            if (regReq.addr == accel_mag_pkg::ADDR_MAG_LSB[k]) begin
                rdMux = magOut.axis[k][7:0];
            end
            // Acceleration left-justified in 16 bits
            if (regReq.addr == accel_mag_pkg::ADDR_ACCEL_FIRST +
                8'(2 * k)) begin
                rdMux = accelOut.axis[k][13:6];
            end
            if (regReq.addr == accel_mag_pkg::ADDR_ACCEL_FIRST +
                8'(2 * k + 1)) begin
                rdMux = {accelOut.axis[k][5:0], 2'b00};
            end
        end
    end

    // Registered read answer
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rd;
            if (regReq.rd) begin
                regRdData <= rdMux;
            end
        end
    end

    // Checks on the logic above
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstSyncN);

    // Write strobe to X offset
    sequence s_xwrite;
        regReq.wr && regReq.addr == accel_mag_pkg::ADDR_ZERO_OFFSET[0];
    endsequence
    // X data reached with ready already set
    sequence s_xlost;
        magDone[0] && readyReg[0] && !msbRead[0];
    endsequence

    property p_offset_hold;
        s_xwrite and deviceActive |=> $stable(offsetReg[0]);
    endproperty
    a_offset_hold: assert property (p_offset_hold)
        else $error("offset changed in active mode");

    property p_offset_write;
        s_xwrite and !deviceActive |=> offsetReg[0] == $past(regReq.wdata);
    endproperty
    a_offset_write: assert property (p_offset_write)
        else $error("offset write not stored");

    property p_accel_sum;
        accelValid |=> accelOut.axis[1] == 14'($past(accelRaw.axis[1]) +
            {{6{$past(offsetReg[1][7])}}, $past(offsetReg[1])});
    endproperty
    a_accel_sum: assert property (p_accel_sum)
        else $error("corrected sample wrong");

    property p_ready_set;
        magDone[2] |=> readyReg[2] ##1 magStatus[2];
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready not set");

    property p_ready_clear;
        msbRead[1] && !magDone[1] |=> !readyReg[1];
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready not cleared by read");

    property p_ow_set;
        s_xlost |=> owReg[0] && xyzOwReg ##1 magStatus[4] && magStatus[7];
    endproperty
    a_ow_set: assert property (p_ow_set)
        else $error("overwrite not flagged");

    property p_zow_clear;
        msbRead[2] && !magDone[2] |=> !owReg[2];
    endproperty
    a_zow_clear: assert property (p_zow_clear)
        else $error("z overwrite not cleared");

    property p_comb_clear;
        allRead && !(|owSet) && !setDone |=> !xyzOwReg && !xyzReadyReg;
    endproperty
    a_comb_clear: assert property (p_comb_clear)
        else $error("combined flags not cleared");

    property p_comb_ready;
        setDone |=> xyzReadyReg;
    endproperty
    a_comb_ready: assert property (p_comb_ready)
        else $error("combined ready missing");

    property p_status_read;
        regReq.rd && regReq.addr == accel_mag_pkg::ADDR_MAG_STATUS
            |=> regRdValid && regRdData == $past(magStatus);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");

    property p_mag_latch;
        magDone[1] |=> magOut.axis[1] == $past(magRaw.axis[1]);
    endproperty
    a_mag_latch: assert property (p_mag_latch)
        else $error("magnetic sample not latched");

    property p_yow_clear;
        msbRead[1] && !magDone[1] |=> !owReg[1];
    endproperty
    a_yow_clear: assert property (p_yow_clear)
        else $error("y overwrite not cleared");

    property p_xow_clear;
        msbRead[0] && !magDone[0] |=> !owReg[0] ##1 !magStatus[4];
    endproperty
    a_xow_clear: assert property (p_xow_clear)
        else $error("x overwrite not cleared");

    property p_comb_ow;
        (|owSet) |=> xyzOwReg;
    endproperty
    a_comb_ow: assert property (p_comb_ow)
        else $error("combined overwrite missing");

    property p_ready_hold;
        readyReg[0] && !msbRead[0] |=> readyReg[0];
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready dropped without read");

    property p_comb_ready_hold;
        xyzReadyReg && !allRead |=> xyzReadyReg;
    endproperty
    a_comb_ready_hold: assert property (p_comb_ready_hold)
        else $error("combined ready dropped early");

endmodule : accel_offset_and_mag_status
`default_nettype wire

// File: sim/host_model.sv
// Host controller model driving register requests.
// Assumes requests are launched on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic core_clk,
    output var accel_mag_pkg::reg_req_t regReq
);
    // Bus idle at start
    initial regReq = '0;
    // One-cycle strobe, then release
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge core_clk);
        regReq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        // Released address and data lines carry the inverse
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : host_model
`default_nettype wire

// File: sim/tb.sv
// Testbench for the offset and magnetic status bank.
// Assumes host_model drives the register requests.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk, arst_n, deviceActive, accelValid, regRdValid;
    logic [2:0] magDone;
    logic [7:0] regRdData, magStatus;
    logic [2:0][7:0] off;
    logic [13:0] e;
    accel_mag_pkg::reg_req_t regReq;
    accel_mag_pkg::accel_sample_t accelRaw, accelOut;
    accel_mag_pkg::mag_sample_t magRaw, magOut;
    int bad_count = 0;
    int checks_done = 0;
    host_model u_host (.core_clk(core_clk), .regReq(regReq));
    accel_offset_and_mag_status u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .regReq(regReq),
        .deviceActive(deviceActive), .accelValid(accelValid),
        .accelRaw(accelRaw), .magDone(magDone), .magRaw(magRaw),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .accelOut(accelOut), .magOut(magOut), .magStatus(magStatus)
    );
    // Clock at 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic check(input string w, input logic [15:0] s, x);
        checks_done++;
        if (s !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", w, x, s);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // Register read with its answer checked
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        u_host.access(1'b0, a, 8'h00);
        check("rdValid", {15'h0, regRdValid}, 16'h1);
        check("regRdData", {8'h0, regRdData}, {8'h0, x});
    endtask : rd
    task automatic stat(input logic [7:0] x);
        repeat (2) @(negedge core_clk);
        check("magStatus", {8'h0, magStatus}, {8'h0, x});
    endtask : stat
    task automatic done(input logic [2:0] m);
        @(negedge core_clk);
        magDone = m;
        @(negedge core_clk);
        magDone = 3'h0;
        repeat (2) @(negedge core_clk);
    endtask : done
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rd(8'h2f + 8'(i), 8'h00);
        rd(8'h7f, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_offset();
        deviceActive = 1'b0;
        off = {8'h7f, 8'h80, 8'(-60 / 2)};
        for (int i = 0; i < 3; i++) u_host.access(1'b1, 8'h2f + 8'(i), off[i]);
        u_host.access(1'b1, 8'h32, 8'hff);
        for (int i = 0; i < 3; i++) rd(8'h2f + 8'(i), off[i]);
        rd(8'h32, 8'h00);
        deviceActive = 1'b1;
        u_host.access(1'b1, 8'h2f, 8'h11);
        rd(8'h2f, off[0]);
        $display("test offset done");
    endtask : t_offset
    task automatic t_accel();
        accelRaw = {14'h1fff, 14'h3fff, 14'h0100};
        @(negedge core_clk);
        accelValid = 1'b1;
        @(negedge core_clk);
        accelValid = 1'b0;
        for (int i = 0; i < 3; i++) begin
            e = accelRaw.axis[i] + {{6{off[i][7]}}, off[i]};
            check("accelOut", {2'h0, accelOut.axis[i]}, {2'h0, e});
            rd(8'h01 + 8'(2 * i), e[13:6]);
            rd(8'h02 + 8'(2 * i), {e[5:0], 2'h0});
        end
        $display("test accel done");
    endtask : t_accel
    task automatic t_ready();
        magRaw = {16'h8001, 16'h1234, 16'hfedc};
        done(3'h7);
        check("magOut", magOut.axis[0], magRaw.axis[0]);
        check("magOut", magOut.axis[2], magRaw.axis[2]);
        stat(8'h0f);
        rd(8'h33, 8'hfe);
        rd(8'h34, 8'hdc);
        stat(8'h0e);
        rd(8'h35, 8'h12);
        rd(8'h37, 8'h80);
        stat(8'h00);
        $display("test ready done");
    endtask : t_ready
    task automatic t_overwrite();
        done(3'h1);
        done(3'h1);
        stat(8'h91);
        done(3'h2);
        done(3'h2);
        stat(8'hb3);
        done(3'h4);
        done(3'h4);
        stat(8'hff);
        rd(8'h32, 8'hff);
        rd(8'h33, 8'hfe);
        stat(8'hee);
        rd(8'h35, 8'h12);
        stat(8'hcc);
        rd(8'h37, 8'h80);
        stat(8'h00);
        $display("test overwrite done");
    endtask : t_overwrite
    // Main sequence
    initial begin
        arst_n = 1'b0;
        deviceActive = 1'b0;
        accelValid = 1'b0;
        magDone = 3'h0;
        accelRaw = '0;
        magRaw = '0;
        off = '0;
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_offset();
        t_accel();
        t_ready();
        t_overwrite();
        print_verdict();
    end
    // Watchdog well beyond the run
    initial begin
        #100us;
        bad_count++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
